// File: hw/fpc_ctrl.sv
// host controller driving a parallel flash's power, reset and command pins
// Functional notes
// RULE1: device refuses program/erase at low supply
// RULE2: device idles low-power after reads
// RULE3: chip select high means standby, outputs float
// RULE4: device finishes operation despite deselect
// RULE5: select low, reset high means active
// RULE6: reset low gives deep power-down
// RULE7: reset low aborts program or erase
// RULE8: deep power-down clears device status
// RULE9: wait recovery times after reset release
// RULE10: write only with write and select low
// RULE11: device alters memory after two-step sequence
// RULE12: device ignores controls while reset low
// RULE13: device keeps latched command across transitions
// RULE14: device defaults to array read
// RULE15: issue array-read before reading array again
// RULE16: reset pin follows system reset
// RULE17: hold reset low during supply ramps
// RULE18: array-read command restores array mode
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fpc_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic reset_powerdown_low,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic [21:0] flash_addr,
    output logic [15:0] dq_o,
    output logic dq_oe_n,
    input wire logic [15:0] dq_i
);
    fpc_pkg::fpc_state_type state_r;
    logic [1:0] ctrl_r;
    logic [21:0] addr_reg_r;
    logic [15:0] rdata_r;
    logic [3:0] irq_st_r;
    logic [3:0] irq_en_r;
    logic [3:0] ev;
    logic [7:0] rec_cnt_r;
    logic [2:0] ph_cnt_r;
    logic [15:0] dq_s1_r;
    logic [15:0] dq_s2_r;
    logic rp_n_r;
    logic need_ar_r;
    logic pend_rd_r;
    logic auto_r;
    logic rd_ok;
    logic wr_ok;
    logic wr_go;
    logic rd_go;
    logic wr_acc;
    logic rd_acc;
    logic rd_auto;
    logic pin_drop;

    // strobes for launching a flash cycle
    assign wr_go = reg_wr && (reg_addr == fpc_pkg::OFS_WDATA);
    assign rd_go = reg_wr && (reg_addr == fpc_pkg::OFS_RDGO);
    assign rd_ok = rec_cnt_r >= 8'(fpc_pkg::PD_EXIT_RD_CYC); // RULE9
    assign wr_ok = rec_cnt_r >= 8'(fpc_pkg::PD_EXIT_WR_CYC); // RULE9
    // a pending array-read write needs write recovery too
    assign rd_auto = need_ar_r; // RULE15
    assign pin_drop = ctrl_r[fpc_pkg::CTRL_PD] || ctrl_r[fpc_pkg::CTRL_RAMP]; // strobes drop with pin
    assign wr_acc = wr_go && state_r == fpc_pkg::FPC_IDLE && rp_n_r && wr_ok && !pin_drop;
    assign rd_acc = rd_go && state_r == fpc_pkg::FPC_IDLE && rp_n_r && rd_ok
        && (!rd_auto || wr_ok) && !pin_drop;

    // pin input synchroniser, dq comes from another timing domain
    always_ff @(posedge sys_clk)
    begin
        dq_s1_r <= dq_i;
        dq_s2_r <= dq_s1_r;
    end

    // software registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_r <= fpc_pkg::CTRL_RST;
            addr_reg_r <= 22'h0;
            irq_en_r <= fpc_pkg::IRQ_EN_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == fpc_pkg::OFS_CTRL)
                ctrl_r <= reg_wdata[1:0];
            if (reg_addr == fpc_pkg::OFS_ADDR)
                addr_reg_r <= reg_wdata[21:0];
            if (reg_addr == fpc_pkg::OFS_IRQ_EN)
                irq_en_r <= reg_wdata[3:0];
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata <= 32'h0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                fpc_pkg::OFS_CTRL: reg_rdata <= {30'h0, ctrl_r};
                fpc_pkg::OFS_ADDR: reg_rdata <= {10'h0, addr_reg_r};
                fpc_pkg::OFS_STAT: reg_rdata <= {27'h0, need_ar_r, wr_ok,
                    rd_ok, rp_n_r, state_r != fpc_pkg::FPC_IDLE};
                fpc_pkg::OFS_RDATA: reg_rdata <= {16'h0, rdata_r};
                fpc_pkg::OFS_IRQ_ST: reg_rdata <= {28'h0, irq_st_r};
                fpc_pkg::OFS_IRQ_EN: reg_rdata <= {28'h0, irq_en_r};
                default: reg_rdata <= 32'h0;
            endcase
        end
        else
            reg_rdata <= 32'h0;
    end

    // reset pin low during system reset, power-down or supply ramp
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rp_n_r <= 1'b0; // RULE16
        else
            rp_n_r <= !pin_drop; // RULE17
    end
    assign reset_powerdown_low = rp_n_r;

    // cycles since reset pin release, saturating
    always_ff @(posedge sys_clk)
    begin
        if (rst || !rp_n_r)
            rec_cnt_r <= 8'h0; // RULE9
        else if (rec_cnt_r != fpc_pkg::REC_MAX)
            rec_cnt_r <= rec_cnt_r + 8'h1;
    end

    // device may hold status mode after any command but array read
    always_ff @(posedge sys_clk)
    begin
        if (rst || !rp_n_r)
            need_ar_r <= 1'b0;
        else if (wr_acc)
            need_ar_r <= reg_wdata[15:0] != fpc_pkg::ARRAY_READ_CMD; // RULE15
        else if (state_r == fpc_pkg::FPC_WEND && auto_r)
            need_ar_r <= 1'b0; // RULE18
    end

    // flash bus cycles; pulling the reset pin low aborts any cycle
    always_ff @(posedge sys_clk)
    begin
        if (rst || !rp_n_r || pin_drop)
        begin
            state_r <= fpc_pkg::FPC_IDLE;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            dq_oe_n <= 1'b1;
            dq_o <= 16'h0;
            flash_addr <= 22'h0;
            ph_cnt_r <= 3'h0;
            pend_rd_r <= 1'b0;
            auto_r <= 1'b0;
            rdata_r <= rdata_r;
        end
        else
        begin
            unique case (state_r)
                fpc_pkg::FPC_IDLE:
                begin
                    ph_cnt_r <= 3'h0;
                    if (wr_acc)
                    begin
                        flash_addr <= addr_reg_r;
                        dq_o <= reg_wdata[15:0];
                        ce_n <= 1'b0;
                        dq_oe_n <= 1'b0;
                        state_r <= fpc_pkg::FPC_WSET;
                    end
                    else if (rd_acc && rd_auto)
                    begin
                        // array-read write goes out before the read
                        flash_addr <= addr_reg_r;
                        dq_o <= fpc_pkg::ARRAY_READ_CMD; // RULE18
                        ce_n <= 1'b0;
                        dq_oe_n <= 1'b0;
                        pend_rd_r <= 1'b1;
                        auto_r <= 1'b1;
                        state_r <= fpc_pkg::FPC_WSET;
                    end
                    else if (rd_acc)
                    begin
                        flash_addr <= addr_reg_r;
                        ce_n <= 1'b0;
                        oe_n <= 1'b0;
                        state_r <= fpc_pkg::FPC_RWAIT;
                    end
                end
                fpc_pkg::FPC_WSET:
                begin
                    we_n <= 1'b0; // RULE10
                    state_r <= fpc_pkg::FPC_WPUL;
                end
                fpc_pkg::FPC_WPUL:
                begin
                    ph_cnt_r <= ph_cnt_r + 3'h1;
                    if (ph_cnt_r == 3'(fpc_pkg::WE_LOW_CYC - 1))
                    begin
                        we_n <= 1'b1;
                        state_r <= fpc_pkg::FPC_WEND;
                    end
                end
                fpc_pkg::FPC_WEND:
                begin
                    // data held one cycle past the rising write strobe
                    dq_oe_n <= 1'b1;
                    ph_cnt_r <= 3'h0;
                    auto_r <= 1'b0;
                    pend_rd_r <= 1'b0;
                    if (pend_rd_r)
                    begin
                        oe_n <= 1'b0;
                        state_r <= fpc_pkg::FPC_RWAIT;
                    end
                    else
                    begin
                        ce_n <= 1'b1;
                        state_r <= fpc_pkg::FPC_IDLE;
                    end
                end
                fpc_pkg::FPC_RWAIT:
                begin
                    ph_cnt_r <= ph_cnt_r + 3'h1;
                    if (ph_cnt_r == 3'(fpc_pkg::RD_ACC_CYC - 1))
                        state_r <= fpc_pkg::FPC_RLAT;
                end
                fpc_pkg::FPC_RLAT:
                begin
                    // sample after sync latency, then deselect
                    rdata_r <= dq_s2_r;
                    oe_n <= 1'b1;
                    ce_n <= 1'b1;
                    state_r <= fpc_pkg::FPC_IDLE;
                end
                default:
                    state_r <= fpc_pkg::FPC_IDLE;
            endcase
        end
    end

    // events; abort when the reset pin falls mid-cycle
    always_comb
    begin
        ev = 4'h0;
        ev[fpc_pkg::EV_WR_DONE] = state_r == fpc_pkg::FPC_WEND && !pend_rd_r;
        ev[fpc_pkg::EV_RD_DONE] = state_r == fpc_pkg::FPC_RLAT && rp_n_r;
        ev[fpc_pkg::EV_REFUSED] = (wr_go && !wr_acc) || (rd_go && !rd_acc);
        ev[fpc_pkg::EV_ABORT] = pin_drop && state_r != fpc_pkg::FPC_IDLE;
    end

    // sticky status, a new event wins over a clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_st_r <= 4'h0;
        else if (reg_wr && reg_addr == fpc_pkg::OFS_IRQ_CLR)
            irq_st_r <= (irq_st_r & ~reg_wdata[3:0]) | ev;
        else
            irq_st_r <= irq_st_r | ev;
    end

    // level interrupt, one cycle behind the status
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irq_st_r & irq_en_r);
    end

    property p_rd_rec;
        @(posedge sys_clk) disable iff (rst)
        $fell(oe_n) |-> rec_cnt_r >= 8'(fpc_pkg::PD_EXIT_RD_CYC);
    endproperty
    a_rd_rec: assert property (p_rd_rec) // RULE9
        else $error("read before read recovery");

    property p_wr_rec;
        @(posedge sys_clk) disable iff (rst)
        $fell(we_n) |-> rec_cnt_r > 8'(fpc_pkg::PD_EXIT_WR_CYC);
    endproperty
    a_wr_rec: assert property (p_wr_rec) // RULE9
        else $error("write before write recovery");

    property p_we_ce;
        @(posedge sys_clk) disable iff (rst)
        !we_n |-> !ce_n && rp_n_r && !dq_oe_n && oe_n;
    endproperty
    a_we_ce: assert property (p_we_ce) // RULE10
        else $error("write strobe without select");

    property p_ar_first;
        @(posedge sys_clk) disable iff (rst)
        $fell(oe_n) |-> !need_ar_r;
    endproperty
    a_ar_first: assert property (p_ar_first) // RULE15
        else $error("array read while device not in array mode");

    property p_rst_rp;
        @(posedge sys_clk)
        rst |=> !reset_powerdown_low ##1 (!reset_powerdown_low || !rst);
    endproperty
    a_rst_rp: assert property (p_rst_rp) // RULE16
        else $error("reset pin not low under system reset");

    property p_ramp;
        @(posedge sys_clk) disable iff (rst)
        ctrl_r[fpc_pkg::CTRL_RAMP] |=> !reset_powerdown_low && ce_n;
    endproperty
    a_ramp: assert property (p_ramp) // RULE17
        else $error("reset pin high during supply ramp");

    property p_ar_code;
        @(posedge sys_clk) disable iff (rst)
        (state_r == fpc_pkg::FPC_WSET && pend_rd_r)
            |-> dq_o == fpc_pkg::ARRAY_READ_CMD ##[1:4] !we_n;
    endproperty
    a_ar_code: assert property (p_ar_code) // RULE18
        else $error("wrong array-read code");
endmodule // fpc_ctrl
`default_nettype wire

// File: hw/fpc_pkg.sv
// constants for the flash power and command controller
package fpc_pkg;
    localparam int CLK_NS = 20;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int BUS_AW = 8;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_RDGO = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_RDATA = 8'h14;
    localparam logic [7:0] OFS_IRQ_ST = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h20;
    // control bit positions
    localparam int CTRL_PD = 0;
    localparam int CTRL_RAMP = 1;
    // interrupt event bit positions
    localparam int EV_WR_DONE = 0;
    localparam int EV_RD_DONE = 1;
    localparam int EV_REFUSED = 2;
    localparam int EV_ABORT = 3;
    localparam int EV_W = 4;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    // array-read command code
    localparam logic [15:0] ARRAY_READ_CMD = 16'h00FF;
    // recovery after power-down exit, in ns
    localparam int PD_EXIT_RD_NS = 150;
    localparam int PD_EXIT_WR_NS = 100;
    // strobe timing, in ns
    localparam int WE_LOW_NS = 60;
    localparam int RD_ACC_NS = 100;
    // least times, rounded up to cycles
    localparam int PD_EXIT_RD_CYC = (PD_EXIT_RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PD_EXIT_WR_CYC = (PD_EXIT_WR_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_ACC_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] REC_MAX = 8'hFF;
    // bus cycle states, gray along the write path only
    typedef enum logic [2:0] {
        FPC_IDLE = 3'h0,
        FPC_WSET = 3'h1,
        FPC_WPUL = 3'h3,
        FPC_WEND = 3'h2,
        FPC_RWAIT = 3'h4,
        FPC_RLAT = 3'h5
    } fpc_state_type;
endpackage

// File: tb/fpc_ctrl_tb_top.sv
// self-checking testbench for the flash power and command controller
`timescale 1ns/100ps
`default_nettype none
module fpc_ctrl_tb_top;
    logic sys_clk = 1'b0;
    logic rst, reg_wr, reg_rd, irq, reset_powerdown_low, ce_n, we_n, oe_n, dq_oe_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [21:0] flash_addr;
    logic [15:0] dq_o, dq_i;
    int bad_count = 0;
    int num_checks = 0;
    // free-running system clock
    always #(fpc_pkg::CLK_NS / 2) sys_clk = ~sys_clk;
    fpc_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .reset_powerdown_low(reset_powerdown_low), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));
    fpc_flash_model i_flash (.reset_powerdown_low(reset_powerdown_low), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .flash_addr(flash_addr), .dq_o(dq_o),
        .dq_oe_n(dq_oe_n), .dq_i(dq_i));
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // all bus tasks end just after a rising edge
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // step off the edge so a following write never re-drives the strobe here
        #1;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // poll one event bit with a bound, then clear it
    task automatic wait_ev(input int b);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 40 && s[b] !== 1'b1; i++)
            reg_read(fpc_pkg::OFS_IRQ_ST, s);
        check32({31'h0, s[b]}, 32'h1);
        reg_write(fpc_pkg::OFS_IRQ_CLR, 32'h1 << b);
    endtask
    // a write strobe without chip select would reach nothing
    always @(posedge sys_clk)
    begin
        if (!rst && we_n === 1'b0)
            check32({31'h0, ce_n}, 32'h0);
    end
    task automatic t_early();
        check32({31'h0, reset_powerdown_low}, 32'h1);
        reg_write(fpc_pkg::OFS_WDATA, 32'h0040);
        reg_read(fpc_pkg::OFS_IRQ_ST, v);
        check32(v, 32'h4);
        check32({31'h0, ce_n}, 32'h1);
        reg_read(fpc_pkg::OFS_CTRL, v);
        check32(v, 32'h0);
        reg_read(fpc_pkg::OFS_IRQ_EN, v);
        check32(v, 32'h0);
        reg_read(8'h24, v);
        check32(v, 32'h0);
        reg_write(fpc_pkg::OFS_IRQ_CLR, 32'hF);
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic t_program();
        reg_write(fpc_pkg::OFS_ADDR, 32'h3);
        reg_write(fpc_pkg::OFS_WDATA, 32'h0040);
        wait_ev(fpc_pkg::EV_WR_DONE);
        reg_write(fpc_pkg::OFS_WDATA, 32'h1234);
        wait_ev(fpc_pkg::EV_WR_DONE);
        check32({16'h0, i_flash.mem[3]}, 32'h1234);
        check32({31'h0, irq}, 32'h0);
        reg_read(fpc_pkg::OFS_STAT, v);
        check32({30'h0, v[4], v[0]}, 32'h2);
    endtask
    task automatic t_read();
        reg_write(fpc_pkg::OFS_RDGO, 32'h0);
        wait_ev(fpc_pkg::EV_RD_DONE);
        reg_read(fpc_pkg::OFS_RDATA, v);
        check32(v, 32'h1234);
        reg_read(fpc_pkg::OFS_STAT, v);
        check32({31'h0, v[4]}, 32'h0);
    endtask
    // program refused while the program supply sits at its lockout level
    task automatic t_lockout();
        i_flash.supply_low = 1'b1;
        reg_write(fpc_pkg::OFS_ADDR, 32'h5);
        reg_write(fpc_pkg::OFS_WDATA, 32'h0040);
        wait_ev(fpc_pkg::EV_WR_DONE);
        reg_write(fpc_pkg::OFS_WDATA, 32'h5678);
        wait_ev(fpc_pkg::EV_WR_DONE);
        check32({16'h0, i_flash.mem[5]}, 32'hFFFF);
        check32({31'h0, i_flash.stat_r[3]}, 32'h1);
        i_flash.supply_low = 1'b0;
    endtask
    task automatic t_irq();
        reg_write(fpc_pkg::OFS_IRQ_EN, 32'h1);
        reg_write(fpc_pkg::OFS_WDATA, 32'h00FF);
        repeat (10) @(posedge sys_clk);
        check32({31'h0, irq}, 32'h1);
        reg_write(fpc_pkg::OFS_IRQ_CLR, 32'h1);
        repeat (2) @(posedge sys_clk);
        check32({31'h0, irq}, 32'h0);
        reg_write(fpc_pkg::OFS_IRQ_EN, 32'h0);
    endtask
    task automatic t_abort();
        reg_write(fpc_pkg::OFS_WDATA, 32'h0040);
        repeat (2) @(posedge sys_clk);
        reg_write(fpc_pkg::OFS_CTRL, 32'h2);
        repeat (2) @(posedge sys_clk);
        check32({29'h0, reset_powerdown_low, ce_n, we_n}, 32'h3);
        check32({16'h0, i_flash.stat_r}, 32'h0);
        reg_read(fpc_pkg::OFS_IRQ_ST, v);
        check32({31'h0, v[fpc_pkg::EV_ABORT]}, 32'h1);
        reg_write(fpc_pkg::OFS_CTRL, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 check32({31'h0, reset_powerdown_low}, 32'h0);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 check32({31'h0, reset_powerdown_low}, 32'h1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // cut a hang short well beyond the expected run
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1 t_early();
        t_program();
        t_read();
        t_lockout();
        t_irq();
        t_abort();
        print_verdict();
    end
endmodule // fpc_ctrl_tb_top
`default_nettype wire

// File: tb/fpc_flash_model.sv
// behavioural model of the parallel flash on the far side
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_model (
    input wire logic reset_powerdown_low,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] dq_o,
    input wire logic dq_oe_n,
    output logic [15:0] dq_i
);
    logic [15:0] mem [0:15];
    logic [15:0] cmd_r = 16'h00FF;
    logic [15:0] stat_r = 16'h0080;
    logic [15:0] last_r = 16'h0000;
    // raised by the bench to model a program supply at its lockout level
    logic supply_low = 1'b0;
    logic [15:0] out_w;
    logic drive;
    // blank array at power-up
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = 16'hFFFF;
    end
    // command latch on strobe release; programs take effect at once
    always @(posedge we_n)
    begin
        if (!ce_n && reset_powerdown_low && !dq_oe_n)
        begin
            if (cmd_r == 16'h0040)
            begin
                // program ends at once, so a later deselect cannot cut it short
                if (supply_low)
                    stat_r = stat_r | 16'h0008;
                else
                    mem[flash_addr[3:0]] = dq_o;
                cmd_r = 16'h0070;
            end
            else
                cmd_r = dq_o;
        end
    end
    // power-down aborts, clears status, returns to array read
    always @(negedge reset_powerdown_low)
    begin
        cmd_r = 16'h00FF;
        stat_r = 16'h0000;
    end
    // outputs only while selected, enabled and powered up
    assign drive = !ce_n && !oe_n && reset_powerdown_low;
    assign out_w = (cmd_r == 16'h00FF) ? mem[flash_addr[3:0]] : stat_r;
    // a floating bus shows the inverse, so stale data never matches
    always @(*)
    begin
        if (drive)
            last_r = out_w;
    end
    assign dq_i = drive ? out_w : ~last_r;
endmodule // fpc_flash_model
`default_nettype wire
